// ===== core/mts_map.vh
/*
 Register offsets, field positions, reset values and encodings for the
 motor type and sensor select block.
 Assumes a 32-bit classic Wishbone slave with word addressing by index.
*/
`ifndef MTS_MAP_VH
`define MTS_MAP_VH
// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define MTS_IDX_MOTOR_CFG 7'h1b
`define MTS_IDX_ELEC_EXT 7'h1c
`define MTS_IDX_VEL_SEL 7'h50
`define MTS_IDX_POS_SEL 7'h51
`define MTS_IDX_ELEC_SEL 7'h52
`define MTS_IDX_ELEC_ANGLE 7'h53
`define MTS_IDX_OP_MODE 7'h63
`define MTS_IDX_STATUS 7'h7e
// ----------------------------------------
// Fields and encodings
// ----------------------------------------
`define MTS_NPP_LSB 0
`define MTS_NPP_MSB 6
`define MTS_TYPE_LSB 16
`define MTS_TYPE_MSB 23
`define MTS_TYPE_NONE 8'h00
`define MTS_TYPE_SINGLE 8'h01
`define MTS_TYPE_TWO 8'h02
`define MTS_TYPE_THREE 8'h03
`define MTS_SRC_EXT 8'h00
`define MTS_SRC_ELEC 8'h01
`define MTS_SRC_MECH 8'h02
`define MTS_MODE_STOP 8'h00
`define MTS_MODE_TORQUE 8'h01
`define MTS_MODE_VELOCITY 8'h02
`define MTS_MODE_POSITION 8'h03
// ----------------------------------------
// Reset values
// ----------------------------------------
`define MTS_RST_NPP 7'h01
`define MTS_RST_TYPE 8'h00
`define MTS_RST_SRC 8'h00
`define MTS_RST_MODE 8'h00
`endif

// ===== core/mts_select.v
/*
 Motor type and angle source selection: register file and datapath
 steering for the servo loops.
 Assumes a classic Wishbone master, synchronous inputs, one clock.
*/
`default_nettype none
`include "mts_map.vh"

// Function
// [R1] Motor type sets gate channel arrangement and transform use or bypass.
// [R2] Two-phase stepper mode bypasses forward and inverse Clarke transforms.
// [R3] Software programs stepper pole pairs as full steps per revolution over four.
// [R4] Software programs three-phase pole pairs as half the pole count.
// [R5] Software should program one pole pair for a DC motor.
// [R6] Multi-phase modes measure two currents and derive the third; DC measures one.
// [R7] A selectable electrical angle source feeds the current loop.
// [R8] Velocity angle source is selectable between electrical and mechanical.
// [R9] Position angle source is selectable; each period is 65536 counts.
// [R10] Torque, velocity and position modes run as cascaded loops.
// [R11] Register space of 128 word addresses, 32 bits each, with packed fields.
module mts_select (
	input wire clk_i,
	input wire rst_n_i,
	input wire cyc_i,
	input wire stb_i,
	input wire we_i,
	input wire [8:0] adr_i,
	input wire [3:0] sel_i,
	input wire [31:0] dat_i,
	output wire [31:0] dat_o,
	output wire ack_o,
	input wire [15:0] electrical_angle_i,
	input wire [15:0] mechanical_angle_i,
	output reg [15:0] commutation_angle_o,
	output reg [15:0] velocity_angle_o,
	output reg [15:0] position_angle_o,
	output reg [6:0] pole_pair_count_o,
	output reg [2:0] gate_channels_o,
	output reg clarke_en_o,
	output reg park_en_o,
	output reg [1:0] current_meas_count_o,
	output reg current_loop_en_o,
	output reg velocity_loop_en_o,
	output reg position_loop_en_o
);

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	reg [6:0] pole_pair_count;
	reg [7:0] motor_type;
	reg [15:0] elec_ext;
	reg [7:0] vel_src;
	reg [7:0] pos_src;
	reg [7:0] elec_src;
	reg [7:0] op_mode;
	reg ack;
	reg [31:0] rdata;
	wire [6:0] idx = adr_i[8:2]; // [R11]
	wire req = cyc_i & stb_i & ~ack;
	// Write lands on the ack edge, so a cycle dropped before ack changes nothing
	wire wr_commit = cyc_i & stb_i & we_i & ack;
	// No motor type means no loop may run, whatever the mode says
	wire motor_known = (motor_type != `MTS_TYPE_NONE);

	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0] be;
		integer k;
		begin
			merge = old;
			for (k = 0; k < 4; k = k + 1)
				if (be[k])
					merge[k*8 +: 8] = nw[k*8 +: 8];
		end
	endfunction

	// Angle mux shared by all three consumers
	function [15:0] pick;
		input [7:0] src;
		input [15:0] e;
		input [15:0] m;
		input [15:0] x;
		begin
			case (src)
				`MTS_SRC_ELEC: pick = e;
				`MTS_SRC_MECH: pick = m;
				default: pick = x;
			endcase
		end
	endfunction

	wire [31:0] motor_word = {8'h00, motor_type, 9'h000, pole_pair_count};
	wire [31:0] motor_new = merge(motor_word, dat_i, sel_i);
	wire [31:0] ext_new = merge({16'h0000, elec_ext}, dat_i, sel_i);

	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pole_pair_count <= `MTS_RST_NPP;
			motor_type <= `MTS_RST_TYPE;
			elec_ext <= 16'h0000;
			vel_src <= `MTS_RST_SRC;
			pos_src <= `MTS_RST_SRC;
			elec_src <= `MTS_RST_SRC;
			op_mode <= `MTS_RST_MODE;
			ack <= 1'b0;
		end else begin
			ack <= req;
			if (wr_commit) begin
				case (idx)
					`MTS_IDX_MOTOR_CFG: begin
						pole_pair_count <= motor_new[`MTS_NPP_MSB:`MTS_NPP_LSB]; // [R11]
						motor_type <= motor_new[`MTS_TYPE_MSB:`MTS_TYPE_LSB];
					end
					`MTS_IDX_ELEC_EXT: elec_ext <= ext_new[15:0];
					`MTS_IDX_VEL_SEL: vel_src <= sel_i[0] ? dat_i[7:0] : vel_src;
					`MTS_IDX_POS_SEL: pos_src <= sel_i[0] ? dat_i[7:0] : pos_src;
					`MTS_IDX_ELEC_SEL: elec_src <= sel_i[0] ? dat_i[7:0] : elec_src;
					`MTS_IDX_OP_MODE: op_mode <= sel_i[0] ? dat_i[7:0] : op_mode;
					default: ;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	reg [31:0] rd;
	always @* begin
		case (idx)
			`MTS_IDX_MOTOR_CFG: rd = motor_word;
			`MTS_IDX_ELEC_EXT: rd = {16'h0000, elec_ext};
			`MTS_IDX_VEL_SEL: rd = {24'h000000, vel_src};
			`MTS_IDX_POS_SEL: rd = {24'h000000, pos_src};
			`MTS_IDX_ELEC_SEL: rd = {24'h000000, elec_src};
			`MTS_IDX_ELEC_ANGLE: rd = {16'h0000, commutation_angle_o};
			`MTS_IDX_OP_MODE: rd = {24'h000000, op_mode};
			`MTS_IDX_STATUS: rd = {16'h0000, 5'h00, clarke_en_o, park_en_o, current_meas_count_o,
				gate_channels_o, 1'b0, current_loop_en_o, velocity_loop_en_o, position_loop_en_o};
			default: rd = 32'h00000000;
		endcase
	end

	// Data held in a flop so the bus sees a stable word with ack
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			rdata <= 32'h00000000;
		else if (req && !we_i)
			rdata <= rd;
	end
	// ----------------------------------------
	// Bus answer
	// ----------------------------------------
	// Registered ack costs a cycle but keeps the bus off long paths
	assign dat_o = rdata;
	assign ack_o = ack;

	// ----------------------------------------
	// Datapath steering
	// ----------------------------------------
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			gate_channels_o <= 3'h0;
			clarke_en_o <= 1'b0;
			park_en_o <= 1'b0;
			current_meas_count_o <= 2'h0;
			pole_pair_count_o <= `MTS_RST_NPP;
			commutation_angle_o <= 16'h0000;
			velocity_angle_o <= 16'h0000;
			position_angle_o <= 16'h0000;
			current_loop_en_o <= 1'b0;
			velocity_loop_en_o <= 1'b0;
			position_loop_en_o <= 1'b0;
		end else begin
			pole_pair_count_o <= pole_pair_count; // Scaling is software's job, not checked here
			// ----------------------------------------
			// Channel and transform decode
			// ----------------------------------------
			case (motor_type)
				`MTS_TYPE_SINGLE: begin
					gate_channels_o <= 3'b001; // [R1]
					clarke_en_o <= 1'b0; // [R1]
					park_en_o <= 1'b0;
					current_meas_count_o <= 2'd1; // [R6]
				end
				`MTS_TYPE_TWO: begin
					gate_channels_o <= 3'b011; // [R1]
					clarke_en_o <= 1'b0; // [R2]
					park_en_o <= 1'b1;
					current_meas_count_o <= 2'd2; // [R6]
				end
				`MTS_TYPE_THREE: begin
					gate_channels_o <= 3'b111; // [R1]
					clarke_en_o <= 1'b1; // [R1]
					park_en_o <= 1'b1;
					current_meas_count_o <= 2'd2; // [R6]
				end
				// Unknown type drives no gates, so a stray write cannot switch the bridge
				default: begin
					gate_channels_o <= 3'b000;
					clarke_en_o <= 1'b0;
					park_en_o <= 1'b0;
					current_meas_count_o <= 2'd0;
				end
			endcase
			// ----------------------------------------
			// Angle routing
			// ----------------------------------------
			// 16-bit angles wrap at 65536 counts per period
			commutation_angle_o <= pick(elec_src, electrical_angle_i, mechanical_angle_i, elec_ext); // [R7]
			velocity_angle_o <= pick(vel_src, electrical_angle_i, mechanical_angle_i, elec_ext); // [R8]
			position_angle_o <= pick(pos_src, electrical_angle_i, mechanical_angle_i, elec_ext); // [R9]
			// ----------------------------------------
			// Loop cascade
			// ----------------------------------------
			// Outer loops always include the inner ones; unknown modes stop all
			current_loop_en_o <= (op_mode != `MTS_MODE_STOP) && (op_mode <= `MTS_MODE_POSITION)
				&& motor_known; // [R10]
			velocity_loop_en_o <= ((op_mode == `MTS_MODE_VELOCITY) || (op_mode == `MTS_MODE_POSITION))
				&& motor_known; // [R10]
			position_loop_en_o <= (op_mode == `MTS_MODE_POSITION) && motor_known; // [R10]
		end
	end

endmodule
`default_nettype wire

// ===== bench/mts_select_asserts.sv
/* Checker on the ports of mts_select.
   Assumes one clock and the async low reset. */
`default_nettype none
module mts_select_asserts(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic ack_o,
	input wire logic clarke_en_o,
	input wire logic park_en_o,
	input wire logic current_loop_en_o,
	input wire logic velocity_loop_en_o,
	input wire logic position_loop_en_o,
	input wire logic [2:0] gate_channels_o,
	input wire logic [1:0] current_meas_count_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	a_ack_one_pulse: assert property (ack_o |=> !ack_o) else $error("ack held");
	a_ack_after_req: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack");
	a_ack_has_cause: assert property (ack_o |-> $past(cyc_i && stb_i && !ack_o)) else $error("stray ack");
	a_stepper_no_clarke: assert property (gate_channels_o == 3'h3 |-> !clarke_en_o && park_en_o
		&& current_meas_count_o == 2'h2) else $error("stepper transforms");
	a_three_phase_full: assert property (gate_channels_o == 3'h7 |-> clarke_en_o && park_en_o
		&& current_meas_count_o == 2'h2) else $error("three phase setup");
	a_dc_bypass_all: assert property (gate_channels_o == 3'h1 |-> !clarke_en_o && !park_en_o
		&& current_meas_count_o == 2'h1) else $error("dc setup");
	a_none_all_off: assert property (gate_channels_o == 3'h0 |-> !clarke_en_o && !park_en_o
		&& current_meas_count_o == 2'h0) else $error("idle setup");
	a_pos_needs_vel: assert property (position_loop_en_o |-> velocity_loop_en_o)
		else $error("position without velocity");
	a_vel_needs_cur: assert property (velocity_loop_en_o |-> current_loop_en_o)
		else $error("velocity without current");
	a_loops_need_type: assert property (current_loop_en_o |-> gate_channels_o != 3'h0)
		else $error("loop without motor");
	c_stepper: cover property (gate_channels_o == 3'h3);
	c_position: cover property (position_loop_en_o);
	c_three_phase: cover property (gate_channels_o == 3'h7 && position_loop_en_o);
	c_read: cover property (ack_o);
endmodule
bind mts_select mts_select_asserts i_chk(
	.clk_i(clk_i),
	.rst_n_i(rst_n_i),
	.cyc_i(cyc_i),
	.stb_i(stb_i),
	.ack_o(ack_o),
	.clarke_en_o(clarke_en_o),
	.park_en_o(park_en_o),
	.current_loop_en_o(current_loop_en_o),
	.velocity_loop_en_o(velocity_loop_en_o),
	.position_loop_en_o(position_loop_en_o),
	.gate_channels_o(gate_channels_o),
	.current_meas_count_o(current_meas_count_o)
);
`default_nettype wire

// ===== bench/mts_sensor_model.sv
/* Position sensor model: mechanical and electrical angle.
   Assumes pole pairs come from the block's own output. */
`default_nettype none
module mts_sensor_model(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [6:0] npp_i,
	output logic [15:0] elec_o,
	output var logic [15:0] mech_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// Odd step, so the angle never repeats per cycle
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) mech_o <= 16'h0;
		else mech_o <= mech_o + 16'h0137;
	end
	assign elec_o = 16'(mech_o * {9'h0, npp_i});
endmodule
`default_nettype wire

// ===== bench/mts_select_tb.sv
/* Random and corner tests of mts_select.
   Assumes the sensor model drives both angle inputs. */
`default_nettype none
module mts_select_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 0, rst_n_i = 0, cyc = 0, stb = 0, we = 0, ack, cl, pk, cu, ve, po;
	logic [8:0] adr = 9'h0;
	logic [31:0] dat = 32'h0, rd, q;
	logic [15:0] el, me, ca, va, pa, e0, m0;
	logic [6:0] pole_pair_count;
	logic [2:0] gc;
	logic [1:0] mc;
	int mismatches = 0, n_checks = 0;
	logic [7:0] t, m, s[3];
	logic [3:0] bs = 4'hf;
	logic [6:0] np;
	int x;
	mts_select i_dut(.clk_i(clk_i), .rst_n_i(rst_n_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
		.sel_i(bs), .dat_i(dat), .dat_o(rd), .ack_o(ack), .electrical_angle_i(el), .mechanical_angle_i(me),
		.commutation_angle_o(ca), .velocity_angle_o(va), .position_angle_o(pa), .pole_pair_count_o(pole_pair_count),
		.gate_channels_o(gc), .clarke_en_o(cl), .park_en_o(pk), .current_meas_count_o(mc),
		.current_loop_en_o(cu), .velocity_loop_en_o(ve), .position_loop_en_o(po));
	mts_sensor_model i_sen(.clk_i(clk_i), .rst_n_i(rst_n_i), .npp_i(pole_pair_count), .elec_o(el), .mech_o(me));
	initial forever #2.5 clk_i = ~clk_i;
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (e !== g) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wb(input logic w, input logic [8:0] a, input logic [31:0] d, input logic [3:0] b = 4'hf);
		int n;
		n = 0;
		@(posedge clk_i);
		{cyc, stb, we, adr, dat, bs} <= {2'h3, w, a, d, b};
		do begin @(posedge clk_i); n++; end while (ack !== 1'b1 && n < 50);
		if (n >= 50) begin
			mismatches++;
			$display("CHECK FAILED ack expected 1 seen %b", ack);
		end
		q = rd;
		{cyc, stb} <= 2'h0;
	endtask
	function automatic logic [15:0] pick(input logic [7:0] c);
		return c == 8'h1 ? e0 : c == 8'h2 ? m0 : 16'h5a3c;
	endfunction
	function automatic logic [2:0] gates(input logic [7:0] c);
		return c == 8'h1 ? 3'h1 : c == 8'h2 ? 3'h3 : c == 8'h3 ? 3'h7 : 3'h0;
	endfunction
	// Ordered current, velocity, position from the top bit down
	function automatic logic [2:0] loops(input logic [7:0] c, input logic [7:0] o);
		return c == 0 || c > 3 || o == 0 || o > 3 ? 3'h0 : o == 1 ? 3'h4 : o == 2 ? 3'h6 : 3'h7;
	endfunction
	function automatic logic [31:0] status(input logic [7:0] c, input logic [7:0] o);
		return {21'h0, c == 8'h3, c == 8'h2 || c == 8'h3, c == 8'h2 || c == 8'h3 ? 2'h2 : c == 8'h1 ? 2'h1 : 2'h0,
			gates(c), 1'b0, loops(c, o)};
	endfunction
	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial begin #100us; mismatches++; end_sim; end
	initial begin
		void'($urandom(32'h83156b7f));
		repeat (16) @(posedge clk_i);
		rst_n_i <= 1;
		chk("npp reset", 7'h1, pole_pair_count);
		wb(0, 9'h040, 0);
		chk("unmapped", 0, q);
		wb(1, 9'h070, 32'h5a3c);
		wb(1, 9'h06c, 32'h00037f55, 4'h4);
		wb(1, 9'h140, 32'h1, 4'he);
		wb(0, 9'h06c, 0);
		chk("byte lanes", 32'h00030001, q);
		wb(0, 9'h140, 0);
		chk("lane 0 only", 0, q);
		for (int i = 0; i < 40; i++) begin
			t = i % 4;
			m = $urandom % 6;
			foreach (s[k]) s[k] = $urandom % 4;
			x = i == 2 ? 200 : 4 * (1 + $urandom % 31);
			np = t == 1 ? 7'h1 : t == 2 ? 7'(x / 4) : 7'(x / 2);
			wb(1, 9'h06c, {8'h0, t, 9'h0, np});
			wb(1, 9'h148, s[0]);
			wb(1, 9'h140, s[1]);
			wb(1, 9'h144, s[2]);
			wb(1, 9'h18c, m);
			wb(0, 9'h06c, 0);
			chk("type", t, q[23:16]);
			chk("npp", np, q[6:0]);
			@(negedge clk_i);
			{e0, m0} = {el, me};
			@(negedge clk_i);
			chk("gates", t == 0 ? 0 : t == 1 ? 1 : t == 2 ? 3 : 7, gc);
			chk("xform", {t == 3, t > 1}, {cl, pk});
			chk("meas", t > 1 ? 2 : t, mc);
			chk("loops", t == 0 || m == 0 || m > 3 ? 0 : m == 1 ? 1 : m == 2 ? 3 : 7, {po, ve, cu});
			chk("comm", pick(s[0]), ca);
			chk("vel", pick(s[1]), va);
			chk("pos", pick(s[2]), pa);
			chk("pole pairs", np, pole_pair_count);
			wb(0, 9'h1f8, 0);
			chk("status", status(t, m), q);
			wb(0, 9'h14c, 0);
			if (s[0] == 0 || s[0] == 3) chk("angle read", 32'h5a3c, q);
			else chk("angle high", 0, q[31:16]);
		end
		@(posedge clk_i) rst_n_i <= 0;
		repeat (2) @(posedge clk_i);
		chk("reset outputs", 0, {cu, ve, po, gc, mc, cl, pk});
		chk("reset angle", 0, ca);
		chk("reset npp", 7'h1, pole_pair_count);
		rst_n_i <= 1;
		wb(0, 9'h06c, 0);
		chk("reset cfg", 32'h1, q);
		end_sim;
	end
endmodule
`default_nettype wire
